//--- rtl/flash_unlock_consts.svh
`ifndef FLASH_UNLOCK_CONSTS_SVH
`define FLASH_UNLOCK_CONSTS_SVH

`define OFF_CTRL_ONE      3'h0
`define OFF_CTRL_TWO      3'h1
`define OFF_PROG_KEY      3'h2
`define OFF_DATA_KEY      3'h3
`define OFF_STATUS        3'h4

`define RST_CTRL_ONE      4'h0
`define RST_CTRL_TWO      8'h00
`define RST_STATUS        8'h40
`define RST_HV_OFF        1'b1
`define KEY_READ_VALUE    8'h00

`define CR1_FIX_BIT       0
`define CR1_IRQ_EN_BIT    1
`define CR1_WAIT_Q_BIT    2
`define CR1_RUN_Q_BIT     3

`define CR2_STD_PRG_BIT   0
`define CR2_FAST_PRG_BIT  4
`define CR2_ERASE_BIT     5
`define CR2_WORD_PRG_BIT  6
`define CR2_OPT_WR_BIT    7

`define ST_PROT_BIT       0
`define ST_PUL_BIT        1
`define ST_DONE_BIT       2
`define ST_DUL_BIT        3
`define ST_HV_BIT         6

`define PROG_KEY_FIRST    8'h5A
`define PROG_KEY_SECOND   8'hC3
`define DATA_KEY_FIRST    8'h3C
`define DATA_KEY_SECOND   8'hA5

`endif

//--- rtl/flash_unlock_pkg.sv
package flash_unlock_pkg;

  typedef enum logic [1:0] {
    KEY_IDLE,
    KEY_HALF,
    KEY_DEAD
  } key_state_t;

endpackage

//--- rtl/rc_flag.sv
`timescale 1ns/1ps

module rc_flag (
  input  wire logic clk_i,
  input  wire logic resetn_i,
  input  wire logic set_i,
  input  wire logic clr_i,
  output logic      flag_o
);

  logic flag_nxt;

  // Set beats clear so a coincident event is kept
  always_comb begin
    flag_nxt = flag_o;
    if (clr_i) begin
      flag_nxt = 1'b0;
    end
    if (set_i) begin
      flag_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      flag_o <= 1'b0;
    end else begin
      flag_o <= flag_nxt;
    end
  end

endmodule

//--- rtl/key_unlock_seq.sv
`timescale 1ns/1ps

module key_unlock_seq
  import flash_unlock_pkg::*;
#(
  parameter logic [7:0] FIRST_KEY  = 8'h00,
  parameter logic [7:0] SECOND_KEY = 8'h00,
  parameter bit         ONE_SHOT   = 1'b0
) (
  input  wire logic       clk_i,
  input  wire logic       resetn_i,
  input  wire logic       key_wr_i,
  input  wire logic [7:0] key_byte_i,
  output logic            unlock_o
);

  key_state_t state_r;
  key_state_t state_nxt;
  logic       unlock_nxt;

  // One-shot variant parks in KEY_DEAD until reset
  always_comb begin
    state_nxt  = state_r;
    unlock_nxt = 1'b0;
    case (state_r)
      KEY_IDLE: begin
        if (key_wr_i) begin
          if (key_byte_i == FIRST_KEY) begin
            state_nxt = KEY_HALF;
          end else if (ONE_SHOT) begin
            state_nxt = KEY_DEAD;
          end
        end
      end
      KEY_HALF: begin
        if (key_wr_i) begin
          unlock_nxt = (key_byte_i == SECOND_KEY);
          state_nxt  = ONE_SHOT ? KEY_DEAD : KEY_IDLE;
        end
      end
      KEY_DEAD: begin
        state_nxt = KEY_DEAD;
      end
      default: begin
        state_nxt = KEY_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_r  <= KEY_IDLE;
      unlock_o <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      unlock_o <= unlock_nxt;
    end
  end

endmodule

//--- rtl/flash_unlock_status_regs.sv
// The strobed register port was decided locally.
`timescale 1ns/1ps
`include "flash_unlock_consts.svh"

// Functional notes
// - Program key register writable, reads zero
// - Data key register writable, reads zero
// - Status resets to high voltage off only
// - High voltage flag follows hardware only
// - Status bits five, four, seven read zero
// - Data unlock set by keys, write-zero clears
// - Program unlock set by keys, write-zero clears
// - Done flag: set on completion, read clears
// - Done flag raises interrupt when enabled
// - Protected write flag set, read clears
// - Protected write flag raises enabled interrupt
// - Write one keeps; read-clear ignores writes
// - Control registers at zero and one, reset zero
// - Program unlock once; bad keys need reset
// - Data keys retry freely after mistake
// - Erase and fast program locked while busy
// - Enable gates the single shared interrupt
module flash_unlock_status_regs
  import flash_unlock_pkg::*;
#(
  parameter logic [7:0] PROG_KEY_A = `PROG_KEY_FIRST,
  parameter logic [7:0] PROG_KEY_B = `PROG_KEY_SECOND,
  parameter logic [7:0] DATA_KEY_A = `DATA_KEY_FIRST,
  parameter logic [7:0] DATA_KEY_B = `DATA_KEY_SECOND
) (
  input  wire logic       clk_i,
  input  wire logic       resetn_i,
  input  wire logic [2:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  input  wire logic       busy_i,
  input  wire logic       op_start_i,
  input  wire logic       op_done_i,
  input  wire logic       hv_on_i,
  input  wire logic       prot_write_i,
  input  wire logic       mem_access_i,
  output logic      [3:0] mem_control_one_o,
  output logic      [7:0] mem_control_two_o,
  output logic            program_area_unlocked_o,
  output logic            data_area_unlocked_o,
  output logic            irq_o
);

  logic [7:0] rdata_nxt;
  logic [3:0] cr1_nxt;
  logic [7:0] cr2_nxt;
  logic       hv_off_r;
  logic       hv_off_nxt;
  logic       irq_nxt;
  logic       done_flag;
  logic       prot_flag;
  logic       prog_unlock_evt;
  logic       data_unlock_evt;
  logic       wr_status;
  logic       rd_status;
  logic       wr_prog_key;
  logic       wr_data_key;
  logic [7:0] status_view;

  function automatic logic hit(input logic strobe, input logic [2:0] a, input logic [2:0] off);
    hit = strobe && (a == off);
  endfunction

  assign wr_status   = hit(wr_i, addr_i, `OFF_STATUS);
  assign rd_status   = hit(rd_i, addr_i, `OFF_STATUS);
  assign wr_prog_key = hit(wr_i, addr_i, `OFF_PROG_KEY);
  assign wr_data_key = hit(wr_i, addr_i, `OFF_DATA_KEY);

  // Reserved and hardware-forced bits held at zero
  assign status_view = {1'b0, hv_off_r, 2'b00, data_area_unlocked_o, done_flag,
                        program_area_unlocked_o, prot_flag};

  key_unlock_seq #(
    .FIRST_KEY  (PROG_KEY_A),
    .SECOND_KEY (PROG_KEY_B),
    .ONE_SHOT   (1'b1)
  ) u_prog_keys (
    .clk_i      (clk_i),
    .resetn_i   (resetn_i),
    .key_wr_i   (wr_prog_key),
    .key_byte_i (wdata_i),
    .unlock_o   (prog_unlock_evt)
  );

  key_unlock_seq #(
    .FIRST_KEY  (DATA_KEY_A),
    .SECOND_KEY (DATA_KEY_B),
    .ONE_SHOT   (1'b0)
  ) u_data_keys (
    .clk_i      (clk_i),
    .resetn_i   (resetn_i),
    .key_wr_i   (wr_data_key),
    .key_byte_i (wdata_i),
    .unlock_o   (data_unlock_evt)
  );

  // Write one leaves unlock bits alone
  rc_flag u_pul (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .set_i    (prog_unlock_evt),
    .clr_i    (wr_status && !wdata_i[`ST_PUL_BIT]),
    .flag_o   (program_area_unlocked_o)
  );

  rc_flag u_dul (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .set_i    (data_unlock_evt),
    .clr_i    (wr_status && !wdata_i[`ST_DUL_BIT]),
    .flag_o   (data_area_unlocked_o)
  );

  // Read-clear flags never look at write data
  rc_flag u_done (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .set_i    (op_done_i),
    .clr_i    (rd_status || op_start_i),
    .flag_o   (done_flag)
  );

  rc_flag u_prot (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .set_i    (prot_write_i),
    .clr_i    (rd_status),
    .flag_o   (prot_flag)
  );

  always_comb begin
    cr1_nxt    = mem_control_one_o;
    cr2_nxt    = mem_control_two_o;
    hv_off_nxt = !hv_on_i;
    irq_nxt    = mem_control_one_o[`CR1_IRQ_EN_BIT] && (done_flag || prot_flag);
    rdata_nxt  = `KEY_READ_VALUE;
    if (mem_access_i) begin
      cr1_nxt[`CR1_RUN_Q_BIT] = 1'b0;
    end
    if (op_done_i) begin
      cr2_nxt[`CR2_WORD_PRG_BIT] = 1'b0;
      cr2_nxt[`CR2_ERASE_BIT]    = 1'b0;
      cr2_nxt[`CR2_FAST_PRG_BIT] = 1'b0;
      cr2_nxt[`CR2_STD_PRG_BIT]  = 1'b0;
    end
    if (hit(wr_i, addr_i, `OFF_CTRL_ONE)) begin
      cr1_nxt = wdata_i[3:0];
    end
    if (hit(wr_i, addr_i, `OFF_CTRL_TWO)) begin
      cr2_nxt[`CR2_OPT_WR_BIT]   = wdata_i[`CR2_OPT_WR_BIT];
      cr2_nxt[`CR2_WORD_PRG_BIT] = wdata_i[`CR2_WORD_PRG_BIT];
      cr2_nxt[`CR2_STD_PRG_BIT]  = wdata_i[`CR2_STD_PRG_BIT];
      // Changing these mid-operation would corrupt the block
      if (!busy_i) begin
        cr2_nxt[`CR2_ERASE_BIT]    = wdata_i[`CR2_ERASE_BIT];
        cr2_nxt[`CR2_FAST_PRG_BIT] = wdata_i[`CR2_FAST_PRG_BIT];
      end
    end
    if (rd_i) begin
      case (addr_i)
        `OFF_CTRL_ONE: rdata_nxt = {4'h0, mem_control_one_o};
        `OFF_CTRL_TWO: rdata_nxt = mem_control_two_o;
        `OFF_STATUS:   rdata_nxt = status_view;
        default:       rdata_nxt = `KEY_READ_VALUE;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mem_control_one_o <= `RST_CTRL_ONE;
      mem_control_two_o <= `RST_CTRL_TWO;
      hv_off_r          <= `RST_HV_OFF;
      irq_o             <= 1'b0;
      rdata_o           <= `KEY_READ_VALUE;
    end else begin
      mem_control_one_o <= cr1_nxt;
      mem_control_two_o <= cr2_nxt;
      hv_off_r          <= hv_off_nxt;
      irq_o             <= irq_nxt;
      rdata_o           <= rdata_nxt;
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);

  AST_PROG_KEY_READ_ZERO: assert property (
    rd_i && addr_i == `OFF_PROG_KEY |=> rdata_o == `KEY_READ_VALUE)
    else $error("program key read not zero");

  AST_DATA_KEY_READ_ZERO: assert property (
    rd_i && addr_i == `OFF_DATA_KEY |=> rdata_o == `KEY_READ_VALUE)
    else $error("data key read not zero");

  AST_STATUS_RESERVED: assert property (
    rd_status |=> rdata_o[7] == 1'b0 && rdata_o[5:4] == 2'b00)
    else $error("reserved status bits nonzero");

  AST_HV_FOLLOWS: assert property (
    rd_status && $past(resetn_i) |=> rdata_o[`ST_HV_BIT] == !$past(hv_on_i, 2))
    else $error("high voltage flag wrong");

  AST_DONE_SET: assert property (
    op_done_i |=> done_flag)
    else $error("done flag not set");

  AST_DONE_READ_CLEAR: assert property (
    rd_status && !op_done_i |=> !done_flag)
    else $error("done flag not cleared by read");

  AST_PROT_SET_WINS: assert property (
    prot_write_i && rd_status |=> prot_flag)
    else $error("protected flag lost on read");

  AST_IRQ_RAISE: assert property (
    mem_control_one_o[`CR1_IRQ_EN_BIT] && (done_flag || prot_flag) |=> irq_o)
    else $error("interrupt not raised");

  AST_IRQ_GATED: assert property (
    !mem_control_one_o[`CR1_IRQ_EN_BIT] |=> !irq_o)
    else $error("interrupt without enable");

  AST_PUL_WRITE_ONE: assert property (
    wr_status && wdata_i[`ST_PUL_BIT] && program_area_unlocked_o |=> program_area_unlocked_o)
    else $error("write one cleared program unlock");

  AST_BUSY_LOCK: assert property (
    hit(wr_i, addr_i, `OFF_CTRL_TWO) && busy_i && !op_done_i
    |=> mem_control_two_o[5:4] == $past(mem_control_two_o[5:4]))
    else $error("erase or fast program changed while busy");

  AST_PROT_SET: assert property (
    prot_write_i |=> prot_flag)
    else $error("protected write flag not set");

  AST_PROT_READ_CLEAR: assert property (
    rd_status && !prot_write_i |=> !prot_flag)
    else $error("protected write flag not cleared by read");

  AST_DONE_START_CLEAR: assert property (
    op_start_i && !op_done_i |=> !done_flag)
    else $error("done flag not cleared by new operation");

  AST_DONE_HOLD: assert property (
    !op_done_i && !op_start_i && !rd_status |=> done_flag == $past(done_flag))
    else $error("done flag changed without cause");

  AST_PUL_SET: assert property (
    prog_unlock_evt |=> program_area_unlocked_o)
    else $error("program unlock flag not set");

  AST_PUL_WRITE_ZERO: assert property (
    wr_status && !wdata_i[`ST_PUL_BIT] && !prog_unlock_evt |=> !program_area_unlocked_o)
    else $error("program unlock flag not cleared by write zero");

  AST_DUL_SET: assert property (
    data_unlock_evt |=> data_area_unlocked_o)
    else $error("data unlock flag not set");

  AST_DUL_WRITE_ZERO: assert property (
    wr_status && !wdata_i[`ST_DUL_BIT] && !data_unlock_evt |=> !data_area_unlocked_o)
    else $error("data unlock flag not cleared by write zero");

  AST_DUL_WRITE_ONE: assert property (
    wr_status && wdata_i[`ST_DUL_BIT] && data_area_unlocked_o |=> data_area_unlocked_o)
    else $error("write one cleared data unlock");

  AST_CTRL_ONE_READ: assert property (
    rd_i && addr_i == `OFF_CTRL_ONE |=> rdata_o == {4'h0, $past(mem_control_one_o)})
    else $error("control one read data wrong");

  AST_CTRL_TWO_READ: assert property (
    rd_i && addr_i == `OFF_CTRL_TWO |=> rdata_o == $past(mem_control_two_o))
    else $error("control two read data wrong");

  AST_CTRL_TWO_RESERVED: assert property (
    mem_control_two_o[3:1] == 3'b000)
    else $error("control two reserved bits nonzero");

  AST_RUN_Q_CLEAR: assert property (
    mem_access_i && !hit(wr_i, addr_i, `OFF_CTRL_ONE) |=> !mem_control_one_o[`CR1_RUN_Q_BIT])
    else $error("run quiescent select not cleared by access");

  AST_OP_BITS_CLEAR: assert property (
    op_done_i && !hit(wr_i, addr_i, `OFF_CTRL_TWO)
    |=> mem_control_two_o[6:4] == 3'b000 && !mem_control_two_o[0])
    else $error("operation bits not cleared on completion");

  AST_PROG_DEAD_STAYS: assert property (
    u_prog_keys.state_r == KEY_DEAD |=> u_prog_keys.state_r == KEY_DEAD)
    else $error("program key sequence left locked state");

  AST_PROG_DEAD_SILENT: assert property (
    u_prog_keys.state_r == KEY_DEAD |=> !prog_unlock_evt)
    else $error("program unlocked twice between resets");

  AST_PROG_BAD_KEY: assert property (
    wr_prog_key && u_prog_keys.state_r == KEY_HALF && wdata_i != PROG_KEY_B
    |=> !prog_unlock_evt)
    else $error("wrong second key unlocked program area");

  AST_DATA_NEVER_DEAD: assert property (
    u_data_keys.state_r != KEY_DEAD)
    else $error("data key sequence locked up");

  AST_IRQ_DROP: assert property (
    !done_flag && !prot_flag |=> !irq_o)
    else $error("interrupt without pending flag");

endmodule

//--- tb/flash_unlock_status_regs_tb.sv
`timescale 1ns/1ps
`include "flash_unlock_consts.svh"

module flash_unlock_status_regs_tb;

  logic       clk_i;
  logic       resetn_i;
  logic [2:0] addr_i;
  logic [7:0] wdata_i;
  logic       wr_i;
  logic       rd_i;
  logic [7:0] rdata_o;
  logic       busy_i;
  logic       op_start_i;
  logic       op_done_i;
  logic       hv_on_i;
  logic       prot_write_i;
  logic       mem_access_i;
  logic [3:0] mem_control_one_o;
  logic [7:0] mem_control_two_o;
  logic       program_area_unlocked_o;
  logic       data_area_unlocked_o;
  logic       irq_o;
  int         err_count = 0;
  int         checks    = 0;

  localparam logic [7:0] PROG_A = `PROG_KEY_FIRST;
  localparam logic [7:0] PROG_B = `PROG_KEY_SECOND;
  localparam logic [7:0] DATA_A = `DATA_KEY_FIRST;
  localparam logic [7:0] DATA_B = `DATA_KEY_SECOND;

  flash_unlock_status_regs i_flash_unlock_status_regs (
    .clk_i                   (clk_i),
    .resetn_i                (resetn_i),
    .addr_i                  (addr_i),
    .wdata_i                 (wdata_i),
    .wr_i                    (wr_i),
    .rd_i                    (rd_i),
    .rdata_o                 (rdata_o),
    .busy_i                  (busy_i),
    .op_start_i              (op_start_i),
    .op_done_i               (op_done_i),
    .hv_on_i                 (hv_on_i),
    .prot_write_i            (prot_write_i),
    .mem_access_i            (mem_access_i),
    .mem_control_one_o       (mem_control_one_o),
    .mem_control_two_o       (mem_control_two_o),
    .program_area_unlocked_o (program_area_unlocked_o),
    .data_area_unlocked_o    (data_area_unlocked_o),
    .irq_o                   (irq_o)
  );

  initial clk_i = 1'b0;
  always #10 clk_i = ~clk_i;

  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic settle();
    @(posedge clk_i);
    #1;
  endtask

  task automatic do_reset();
    @(posedge clk_i);
    resetn_i <= 1'b0;
    repeat (12) @(posedge clk_i);
    resetn_i <= 1'b1;
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i    <= 1'b0;
  endtask

  // Both key bytes back to back, no idle cycle between them
  task automatic key2(input logic [2:0] a, input logic [7:0] k0, input logic [7:0] k1);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= k0;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wdata_i <= k1;
    @(posedge clk_i);
    wr_i    <= 1'b0;
    settle();
  endtask

  task automatic rd(input logic [2:0] a, input logic [7:0] exp, input string name);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i   <= 1'b0;
    #1;
    chk(name, exp, rdata_o);
  endtask

  // One-cycle engine events; flags land on the edge that ends the pulse
  task automatic ev(input logic done, input logic prot, input logic start, input logic acc);
    @(posedge clk_i);
    op_done_i    <= done;
    prot_write_i <= prot;
    op_start_i   <= start;
    mem_access_i <= acc;
    @(posedge clk_i);
    {op_done_i, prot_write_i, op_start_i, mem_access_i} <= 4'h0;
  endtask

  task automatic t_reset_vals();
    rd(`OFF_STATUS, 8'h40, "status");
    rd(`OFF_CTRL_ONE, 8'h00, "ctrl1");
    rd(`OFF_CTRL_TWO, 8'h00, "ctrl2");
    rd(3'h5, 8'h00, "unmapped");
  endtask

  task automatic t_data_key();
    wr(`OFF_DATA_KEY, 8'hFF);
    key2(`OFF_DATA_KEY, DATA_A, DATA_B);
    chk("dul", 8'h01, {7'h0, data_area_unlocked_o});
    rd(`OFF_DATA_KEY, 8'h00, "dkey");
    rd(`OFF_STATUS, 8'h48, "status dul");
    wr(`OFF_STATUS, 8'h08);
    rd(`OFF_STATUS, 8'h48, "dul w1");
    wr(`OFF_STATUS, 8'h00);
    rd(`OFF_STATUS, 8'h40, "dul w0");
  endtask

  task automatic t_prog_key();
    key2(`OFF_PROG_KEY, PROG_A, PROG_B);
    chk("pul", 8'h01, {7'h0, program_area_unlocked_o});
    rd(`OFF_PROG_KEY, 8'h00, "pkey");
    wr(`OFF_STATUS, 8'h02);
    rd(`OFF_STATUS, 8'h42, "pul w1");
    wr(`OFF_STATUS, 8'h00);
    rd(`OFF_STATUS, 8'h40, "pul w0");
    key2(`OFF_PROG_KEY, PROG_A, PROG_B);
    chk("pul again", 8'h00, {7'h0, program_area_unlocked_o});
    do_reset();
    key2(`OFF_PROG_KEY, PROG_A, 8'h00);
    key2(`OFF_PROG_KEY, PROG_A, PROG_B);
    chk("pul dead", 8'h00, {7'h0, program_area_unlocked_o});
  endtask

  task automatic t_events();
    ev(1'b1, 1'b0, 1'b0, 1'b0);
    settle();
    chk("irq off", 8'h00, {7'h0, irq_o});
    rd(`OFF_STATUS, 8'h44, "done");
    rd(`OFF_STATUS, 8'h40, "done rc");
    wr(`OFF_CTRL_ONE, 8'h02);
    ev(1'b1, 1'b0, 1'b0, 1'b0);
    settle();
    chk("irq done", 8'h01, {7'h0, irq_o});
    ev(1'b0, 1'b0, 1'b1, 1'b0);
    settle();
    chk("irq start", 8'h00, {7'h0, irq_o});
    ev(1'b0, 1'b1, 1'b0, 1'b0);
    settle();
    chk("irq prot", 8'h01, {7'h0, irq_o});
    wr(`OFF_STATUS, 8'h00);
    rd(`OFF_STATUS, 8'h41, "prot w0");
    rd(`OFF_STATUS, 8'h40, "prot rc");
    // Read and hardware set in one cycle: the set must survive
    @(posedge clk_i);
    addr_i       <= `OFF_STATUS;
    rd_i         <= 1'b1;
    prot_write_i <= 1'b1;
    @(posedge clk_i);
    rd_i         <= 1'b0;
    prot_write_i <= 1'b0;
    rd(`OFF_STATUS, 8'h41, "set wins");
    @(posedge clk_i);
    hv_on_i <= 1'b1;
    wr(`OFF_STATUS, 8'h4A);
    rd(`OFF_STATUS, 8'h00, "hv on");
    @(posedge clk_i);
    hv_on_i <= 1'b0;
    rd(`OFF_STATUS, 8'h40, "hv off");
  endtask

  task automatic t_ctrl();
    @(posedge clk_i);
    busy_i <= 1'b1;
    wr(`OFF_CTRL_TWO, 8'h30);
    rd(`OFF_CTRL_TWO, 8'h00, "ctrl2 busy");
    @(posedge clk_i);
    busy_i <= 1'b0;
    wr(`OFF_CTRL_TWO, 8'hF1);
    rd(`OFF_CTRL_TWO, 8'hF1, "ctrl2");
    chk("ctrl2 out", 8'hF1, mem_control_two_o);
    ev(1'b1, 1'b0, 1'b0, 1'b0);
    rd(`OFF_CTRL_TWO, 8'h80, "ctrl2 done");
    wr(`OFF_CTRL_ONE, 8'h0F);
    rd(`OFF_CTRL_ONE, 8'h0F, "ctrl1");
    ev(1'b0, 1'b0, 1'b0, 1'b1);
    settle();
    chk("ctrl1 acc", 8'h07, {4'h0, mem_control_one_o});
  endtask

  // Whole run is under 150 cycles; this bound only cuts a hang
  initial begin
    #50us;
    err_count++;
    stop_test();
  end

  initial begin
    resetn_i = 1'b0;
    addr_i = 3'h0;
    wdata_i = 8'h00;
    {wr_i, rd_i, busy_i, op_start_i, op_done_i} = 5'h00;
    {hv_on_i, prot_write_i, mem_access_i} = 3'h0;
    do_reset();
    t_reset_vals();
    t_data_key();
    t_prog_key();
    t_events();
    t_ctrl();
    stop_test();
  end

endmodule
